// file: shared/lbp_pkg.sv
// Constants, register map and shared helpers for the blink and PWM block.
package lbp_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int LBP_CLK_NS = 40;
    localparam int LBP_TICK_NS = 62_500_000;
    localparam int LBP_TICK_CYC = LBP_TICK_NS / LBP_CLK_NS;
    localparam int LBP_PWM_PERIOD_NS = 2_000_000;
    localparam int LBP_PWM_SLOTS = 256;
    localparam int LBP_PWM_SLOT_CYC = LBP_PWM_PERIOD_NS / (LBP_PWM_SLOTS * LBP_CLK_NS);

    // ------------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam int LBP_ADDR_W = 10;
    localparam logic [7:0] LBP_IDX_BLINK_PERIOD = 8'h6c;
    localparam logic [7:0] LBP_IDX_BLINK_PULSE = 8'h6d;
    localparam logic [7:0] LBP_IDX_PWM_RATE = 8'h6e;
    localparam logic [7:0] LBP_IDX_PWM_DUTY = 8'h6f;
    localparam logic [7:0] LBP_IDX_SCRATCH = 8'h70;
    localparam logic [7:0] LBP_IDX_REVISION = 8'h80;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int LBP_PER_A_LSB = 0;
    localparam int LBP_PER_B_LSB = 3;
    localparam int LBP_LEN_A_LSB = 0;
    localparam int LBP_LEN_B_LSB = 2;
    localparam int LBP_DBL_A_BIT = 4;
    localparam int LBP_DBL_B_BIT = 5;
    localparam int LBP_BOOT_BIT = 7;
    localparam logic [7:0] LBP_RST_VAL = 8'h00;
    localparam logic [1:0] LBP_RESP_OKAY = 2'h0;
    localparam logic [1:0] LBP_RESP_DECERR = 2'h3;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lbp_pow2(input logic [2:0] n);
        return 8'h01 << n;
    endfunction

endpackage

// file: shared/lbp_blink_if.sv
// Configuration and output carrier between the top and one blink channel.
`timescale 1ns/1ns
interface lbp_blink_if;
    logic tick;
    logic [2:0] period_sel;
    logic [1:0] pulse_len;
    logic double_pulse;
    logic blink_out;

    modport ctrl
    (
        output tick,
        output period_sel,
        output pulse_len,
        output double_pulse,
        input blink_out
    );

    modport chan
    (
        input tick,
        input period_sel,
        input pulse_len,
        input double_pulse,
        output blink_out
    );
endinterface

// file: rtl/lbp_blink_chan.sv
// One on/off blink pulse generator counting in 62.5 ms ticks.
`timescale 1ns/1ns
module lbp_blink_chan
    import lbp_pkg::*;
(
    input wire logic aclk,
    input wire logic ce,
    input wire logic rst_n,
    lbp_blink_if.chan bif
);

    // ------------------------------------------------------------------
    // Pattern decode
    // ------------------------------------------------------------------
    logic [7:0] pos_q;
    logic out_q;
    wire logic chan_en = (bif.period_sel != 3'h0);
    wire logic [7:0] period_ticks = lbp_pow2(bif.period_sel);
    wire logic [7:0] on_ticks = lbp_pow2({1'b0, bif.pulse_len});
    wire logic [7:0] on2_ticks = 8'(on_ticks << 1);
    wire logic [7:0] on3_ticks = 8'(on2_ticks + on_ticks);
    // Compare with >= so a shorter period written mid-cycle wraps on the next tick.
    wire logic pos_wrap = (pos_q >= 8'(period_ticks - 8'h01));
    wire logic first_on = (pos_q < on_ticks);
    wire logic second_on = bif.double_pulse && (pos_q >= on2_ticks) && (pos_q < on3_ticks);
    wire logic out_d = chan_en && (first_on || second_on);

    // ------------------------------------------------------------------
    // Position counter and output
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!rst_n)
        begin
            pos_q <= 8'h00;
            out_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!chan_en)
                pos_q <= 8'h00;
            else if (bif.tick)
                pos_q <= pos_wrap ? 8'h00 : 8'(pos_q + 8'h01);
            out_q <= out_d;
        end
    end

    assign bif.blink_out = out_q;

endmodule

// file: rtl/lbp_top.sv
// Top of the two-channel blink generator and PWM generator with AXI4-Lite registers.
//
// Behaviour
// - Channel A period code; 000 off, doubles.
// - Channel B period code; same doubling encoding.
// - Channel A pulse length 62.5 to 500 ms.
// - Channel B pulse length 62.5 to 500 ms.
// - Channel A double pulse when pattern set.
// - Channel B double pulse when pattern set.
// - PWM rate code selects 500 down to 62.5 Hz.
// - PWM duty is value over 256.
// - Revision bit seven enables boot mode read.
// - Revision low nibble is read-only silicon code.
// - General reset clears blink and PWM registers.
// - Scratch and revision reset only by full reset.
`timescale 1ns/1ns
module lbp_top
    import lbp_pkg::*;
#(
    parameter int TICK_CYCLES = LBP_TICK_CYC,
    parameter int SLOT_CYCLES = LBP_PWM_SLOT_CYC,
    // Arbitrary revision value.
    parameter logic [3:0] REV_CODE = 4'h5
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic general_resetn,
    input wire logic ce,
    input wire logic [LBP_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [LBP_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic blink_out_a,
    output logic blink_out_b,
    output logic pwm_out,
    output logic boot_read_en
);

    // ------------------------------------------------------------------
    // Resets
    // ------------------------------------------------------------------
    // The control registers sit in the general domain, which the full
    // reset also clears; scratch and revision see only the full reset.
    wire logic gen_rst_n = aresetn && general_resetn;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] blink_period_ctrl_q;
    logic [7:0] blink_pulse_ctrl_q;
    logic [7:0] pwm_rate_ctrl_q;
    logic [7:0] pwm_duty_ctrl_q;
    logic [7:0] scratch_byte_q;
    logic boot_read_en_q;

    // ------------------------------------------------------------------
    // Write channel holding
    // ------------------------------------------------------------------
    logic aw_have_q;
    logic w_have_q;
    logic [LBP_ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic awready_q;
    logic wready_q;

    wire logic aw_take = awvalid && awready_q;
    wire logic w_take = wvalid && wready_q;
    wire logic wr_fire = aw_have_q && w_have_q && !bvalid_q;
    // Readies are built from the next hold state so they leave a flop.
    wire logic aw_have_d = !wr_fire && (aw_have_q || aw_take);
    wire logic w_have_d = !wr_fire && (w_have_q || w_take);
    wire logic bvalid_d = wr_fire || (bvalid_q && !bready);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic [7:0] wr_idx = aw_addr_q[LBP_ADDR_W-1:2];
    wire logic wr_algn = (aw_addr_q[1:0] == 2'h0);
    wire logic wr_en = wr_fire && w_lane0_q;
    wire logic wr_period = wr_algn && (wr_idx == LBP_IDX_BLINK_PERIOD);
    wire logic wr_pulse = wr_algn && (wr_idx == LBP_IDX_BLINK_PULSE);
    wire logic wr_rate = wr_algn && (wr_idx == LBP_IDX_PWM_RATE);
    wire logic wr_duty = wr_algn && (wr_idx == LBP_IDX_PWM_DUTY);
    wire logic wr_scratch = wr_algn && (wr_idx == LBP_IDX_SCRATCH);
    wire logic wr_rev = wr_algn && (wr_idx == LBP_IDX_REVISION);
    wire logic wr_hit = wr_period || wr_pulse || wr_rate || wr_duty || wr_scratch || wr_rev;

    wire logic [7:0] rd_idx = araddr[LBP_ADDR_W-1:2];
    wire logic rd_algn = (araddr[1:0] == 2'h0);
    wire logic rd_period = rd_algn && (rd_idx == LBP_IDX_BLINK_PERIOD);
    wire logic rd_pulse = rd_algn && (rd_idx == LBP_IDX_BLINK_PULSE);
    wire logic rd_rate = rd_algn && (rd_idx == LBP_IDX_PWM_RATE);
    wire logic rd_duty = rd_algn && (rd_idx == LBP_IDX_PWM_DUTY);
    wire logic rd_scratch = rd_algn && (rd_idx == LBP_IDX_SCRATCH);
    wire logic rd_rev = rd_algn && (rd_idx == LBP_IDX_REVISION);
    wire logic rd_hit = rd_period || rd_pulse || rd_rate || rd_duty || rd_scratch || rd_rev;
    wire logic ar_take = arvalid && arready_q;

    // Reserved bits are never stored, so they read back as zero.
    wire logic [7:0] rev_view = {boot_read_en_q, 3'h0, REV_CODE};
    wire logic [7:0] rd_byte =
        rd_period ? blink_period_ctrl_q :
        rd_pulse ? blink_pulse_ctrl_q :
        rd_rate ? pwm_rate_ctrl_q :
        rd_duty ? pwm_duty_ctrl_q :
        rd_scratch ? scratch_byte_q :
        rd_rev ? rev_view : 8'h00;

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= LBP_RESP_OKAY;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end
        else if (ce)
        begin
            awready_q <= !aw_have_d && !bvalid_d;
            wready_q <= !w_have_d && !bvalid_d;
            if (aw_take)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (w_take)
            begin
                w_have_q <= 1'b1;
                w_byte_q <= wdata[7:0];
                w_lane0_q <= wstrb[0];
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? LBP_RESP_OKAY : LBP_RESP_DECERR;
            end
            else if (bvalid_q && bready)
                bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= LBP_RESP_OKAY;
        end
        else if (ce)
        begin
            if (ar_take)
            begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= {24'h00_0000, rd_byte};
                rresp_q <= rd_hit ? LBP_RESP_OKAY : LBP_RESP_DECERR;
            end
            else if (rvalid_q && rready)
            begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers, general domain
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!gen_rst_n)
        begin
            blink_period_ctrl_q <= LBP_RST_VAL;
            blink_pulse_ctrl_q <= LBP_RST_VAL;
            pwm_rate_ctrl_q <= LBP_RST_VAL;
            pwm_duty_ctrl_q <= LBP_RST_VAL;
        end
        else if (ce && wr_en)
        begin
            if (wr_period)
                blink_period_ctrl_q <= {2'h0, w_byte_q[5:0]};
            if (wr_pulse)
                blink_pulse_ctrl_q <= {2'h0, w_byte_q[5:0]};
            if (wr_rate)
                pwm_rate_ctrl_q <= {6'h00, w_byte_q[1:0]};
            if (wr_duty)
                pwm_duty_ctrl_q <= w_byte_q;
        end
    end

    // ------------------------------------------------------------------
    // Scratch and revision, full domain only
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scratch_byte_q <= LBP_RST_VAL;
            boot_read_en_q <= 1'b0;
        end
        else if (ce && wr_en)
        begin
            if (wr_scratch)
                scratch_byte_q <= w_byte_q;
            if (wr_rev)
                boot_read_en_q <= w_byte_q[LBP_BOOT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Blink tick, one pulse every 62.5 ms
    // ------------------------------------------------------------------
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick_q;
    wire logic tick_end = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge aclk)
    begin
        if (!gen_rst_n)
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (ce)
        begin
            tick_cnt_q <= tick_end ? '0 : TICK_W'(tick_cnt_q + 1'b1);
            tick_q <= tick_end;
        end
    end

    // ------------------------------------------------------------------
    // Blink channels
    // ------------------------------------------------------------------
    lbp_blink_if bif_a ();
    lbp_blink_if bif_b ();

    assign bif_a.tick = tick_q;
    assign bif_a.period_sel = blink_period_ctrl_q[LBP_PER_A_LSB +: 3];
    assign bif_a.pulse_len = blink_pulse_ctrl_q[LBP_LEN_A_LSB +: 2];
    assign bif_a.double_pulse = blink_pulse_ctrl_q[LBP_DBL_A_BIT];
    assign bif_b.tick = tick_q;
    assign bif_b.period_sel = blink_period_ctrl_q[LBP_PER_B_LSB +: 3];
    assign bif_b.pulse_len = blink_pulse_ctrl_q[LBP_LEN_B_LSB +: 2];
    assign bif_b.double_pulse = blink_pulse_ctrl_q[LBP_DBL_B_BIT];

    lbp_blink_chan u_chan_a
    (
        .aclk(aclk),
        .ce(ce),
        .rst_n(gen_rst_n),
        .bif(bif_a)
    );

    lbp_blink_chan u_chan_b
    (
        .aclk(aclk),
        .ce(ce),
        .rst_n(gen_rst_n),
        .bif(bif_b)
    );

    // ------------------------------------------------------------------
    // PWM generator
    // ------------------------------------------------------------------
    // The 2 ms base period is not a whole number of 40 ns cycles per slot,
    // so each slot rounds down and the real rate runs slightly fast.
    localparam int DIV_W = $clog2((SLOT_CYCLES << 3) + 1);
    logic [DIV_W-1:0] slot_div_q;
    logic [7:0] slot_q;
    logic pwm_q;
    wire logic [DIV_W-1:0] slot_lim = DIV_W'((SLOT_CYCLES << pwm_rate_ctrl_q[1:0]) - 1);
    wire logic slot_end = (slot_div_q >= slot_lim);
    wire logic pwm_d = (slot_q < pwm_duty_ctrl_q);

    always_ff @(posedge aclk)
    begin
        if (!gen_rst_n)
        begin
            slot_div_q <= '0;
            slot_q <= 8'h00;
            pwm_q <= 1'b0;
        end
        else if (ce)
        begin
            slot_div_q <= slot_end ? '0 : DIV_W'(slot_div_q + 1'b1);
            if (slot_end)
                slot_q <= 8'(slot_q + 8'h01);
            pwm_q <= pwm_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign blink_out_a = bif_a.blink_out;
    assign blink_out_b = bif_b.blink_out;
    assign pwm_out = pwm_q;
    assign boot_read_en = boot_read_en_q;

endmodule

// file: tb/lbp_monitor.sv
// Checker of bus timing and output behaviour, bound to the blink and PWM top.
`timescale 1ns/1ns
module lbp_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic general_resetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic blink_out_a,
    input wire logic blink_out_b,
    input wire logic pwm_out,
    input wire logic boot_read_en
);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_aw_taken;
        awvalid && awready;
    endsequence
    sequence s_w_taken;
        wvalid && wready;
    endsequence
    sequence s_b_answer;
        !bvalid ##1 bvalid;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_WR_ANSWER: assert property ((s_aw_taken and s_w_taken) |=> s_b_answer)
        else $error("write response not two cycles after address and data");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before it was taken");
    AST_B_RELEASE: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write channel not free after response");
    AST_W_REFUSE: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data not one cycle after address");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before it was taken");
    AST_RDATA_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("unused read bits not zero");
    AST_BOOT_EN: assert property ($changed(boot_read_en) |-> $rose(bvalid))
        else $error("boot read enable moved without a write");
    AST_GRST_OUTS: assert property (!general_resetn [*3] |->
        !blink_out_a && !blink_out_b && !pwm_out)
        else $error("outputs active during general reset");
endmodule

bind lbp_top lbp_monitor i_lbp_monitor (.aclk, .aresetn, .general_resetn, .awvalid, .awready,
    .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
    .blink_out_a, .blink_out_b, .pwm_out, .boot_read_en);

// file: tb/lbp_load_model.sv
// Model of the LEDs and PWM load: counts the cycles each output is lit.
`timescale 1ns/1ns
module lbp_load_model
(
    input wire logic aclk,
    input wire logic run,
    input wire logic blink_out_a,
    input wire logic blink_out_b,
    input wire logic pwm_out,
    output logic [31:0] cnt_a,
    output logic [31:0] cnt_b,
    output logic [31:0] cnt_p
);
    logic run_q = 1'b0;

    // Counting over whole periods makes the result independent of phase.
    always_ff @(posedge aclk)
    begin
        run_q <= run;
        if (run && !run_q)
        begin
            cnt_a <= 32'(blink_out_a);
            cnt_b <= 32'(blink_out_b);
            cnt_p <= 32'(pwm_out);
        end
        else if (run)
        begin
            cnt_a <= cnt_a + 32'(blink_out_a);
            cnt_b <= cnt_b + 32'(blink_out_b);
            cnt_p <= cnt_p + 32'(pwm_out);
        end
    end
endmodule

// file: tb/lbp_top_test.sv
// Self-checking bench for the blink and PWM top over AXI4-Lite.
`timescale 1ns/1ns
module lbp_top_test
    import lbp_pkg::*;
;
    localparam int TICK = 10;
    localparam int SLOT = 2;
    // Arbitrary revision value.
    localparam logic [3:0] REV = 4'ha;
    logic aclk, aresetn, general_resetn, ce, awvalid, wvalid, bready, arvalid, rready, run;
    logic awready, wready, bvalid, arready, rvalid, blink_out_a, blink_out_b, pwm_out;
    logic boot_read_en;
    logic [LBP_ADDR_W-1:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata, cnt_a, cnt_b, cnt_p;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int i, w;
    logic [7:0] idx_l [6] = '{LBP_IDX_BLINK_PERIOD, LBP_IDX_BLINK_PULSE, LBP_IDX_PWM_RATE,
        LBP_IDX_PWM_DUTY, LBP_IDX_SCRATCH, LBP_IDX_REVISION};
    logic [7:0] msk_l [6] = '{8'h3f, 8'h3f, 8'h03, 8'hff, 8'hff, {4'h8, REV}};
    int bt [8][6] = '{'{1, 0, 0, 0, 0, 0}, '{3, 1, 1, 2, 1, 1}, '{7, 3, 1, 3, 0, 1},
        '{2, 3, 0, 7, 2, 0}, '{4, 2, 1, 5, 0, 0}, '{6, 1, 0, 1, 1, 1},
        '{5, 0, 1, 6, 3, 1}, '{0, 0, 0, 4, 2, 1}};
    int pt [4][2] = '{'{0, 'h00}, '{1, 'h01}, '{2, 'h80}, '{3, 'hff}};

    lbp_top #(.TICK_CYCLES(TICK), .SLOT_CYCLES(SLOT), .REV_CODE(REV)) i_lbp_top (.aclk,
        .aresetn, .general_resetn, .ce, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .blink_out_a, .blink_out_b, .pwm_out, .boot_read_en);
    lbp_load_model i_lbp_load_model (.aclk, .run, .blink_out_a, .blink_out_b, .pwm_out,
        .cnt_a, .cnt_b, .cnt_p);

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_data({30'h0, got}, {30'h0, exp});
    endtask

    // Ready is raised late on purpose so the slave must hold its answer.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] stb,
        input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= stb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (n == 3)
                bready <= 1'b1;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        cmp_resp(bresp, er);
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
            if (n == 2)
                rready <= 1'b1;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        cmp_data(rdata, {24'h0, ed});
        cmp_resp(rresp, er);
        @(posedge aclk);
    endtask

    task automatic measure(input int cycles);
        repeat (cycles) @(posedge aclk);
        run <= 1'b1;
        repeat (cycles) @(posedge aclk);
        run <= 1'b0;
        @(posedge aclk);
    endtask

    function automatic int hi_ticks(input int code, input int len, input int dbl);
        int p, on, h;
        if (code == 0)
            return 0;
        p = 1 << code;
        on = 1 << len;
        h = (on < p) ? on : p;
        if (dbl != 0 && 2 * on < p)
            h += ((3 * on < p) ? 3 * on : p) - 2 * on;
        return h;
    endfunction

    // ------------------------------------------------------------------
    // Clock, timeout and tests
    // ------------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            close_out();
        end
    end

    initial
    begin
        {aresetn, ce, general_resetn, awvalid, wvalid, bready, arvalid, rready, run} = 9'h0c0;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 6; i++)
            rd(idx_l[i], (i == 5) ? {4'h0, REV} : 8'h00, LBP_RESP_OKAY);
        for (i = 0; i < 6; i++)
        begin
            wr(idx_l[i], 8'hff, 4'hf, LBP_RESP_OKAY);
            rd(idx_l[i], msk_l[i], LBP_RESP_OKAY);
        end
        cmp_data({31'h0, boot_read_en}, 32'h1);
        wr(LBP_IDX_REVISION, 8'h0f, 4'h1, LBP_RESP_OKAY);
        cmp_data({31'h0, boot_read_en}, 32'h0);
        wr(8'h71, 8'h12, 4'h1, LBP_RESP_DECERR);
        rd(8'h71, 8'h00, LBP_RESP_DECERR);
        wr(LBP_IDX_SCRATCH, 8'h00, 4'he, LBP_RESP_OKAY);
        rd(LBP_IDX_SCRATCH, 8'hff, LBP_RESP_OKAY);
        // Each case starts from period code zero so the position counter is clean.
        for (i = 0; i < 8; i++)
        begin
            wr(LBP_IDX_BLINK_PERIOD, 8'h00, 4'h1, LBP_RESP_OKAY);
            wr(LBP_IDX_BLINK_PULSE, {2'h0, bt[i][5][0], bt[i][2][0], bt[i][4][1:0],
                bt[i][1][1:0]}, 4'h1, LBP_RESP_OKAY);
            wr(LBP_IDX_BLINK_PERIOD, {2'h0, bt[i][3][2:0], bt[i][0][2:0]}, 4'h1, LBP_RESP_OKAY);
            w = TICK << ((bt[i][0] > bt[i][3]) ? bt[i][0] : bt[i][3]);
            measure(w);
            cmp_data(cnt_a, hi_ticks(bt[i][0], bt[i][1], bt[i][2]) * (w >> bt[i][0]));
            cmp_data(cnt_b, hi_ticks(bt[i][3], bt[i][4], bt[i][5]) * (w >> bt[i][3]));
        end
        for (i = 0; i < 4; i++)
        begin
            wr(LBP_IDX_PWM_RATE, 8'(pt[i][0]), 4'h1, LBP_RESP_OKAY);
            wr(LBP_IDX_PWM_DUTY, 8'(pt[i][1]), 4'h1, LBP_RESP_OKAY);
            w = (256 * SLOT) << pt[i][0];
            measure(w);
            cmp_data(cnt_p, (pt[i][1] * SLOT) << pt[i][0]);
        end
        // Channel B still toggles every 40 cycles, so a live clock enable would show.
        ce <= 1'b0;
        repeat (2) @(posedge aclk);
        w = {blink_out_a, blink_out_b, pwm_out};
        repeat (50) @(posedge aclk);
        cmp_data({29'h0, blink_out_a, blink_out_b, pwm_out}, 32'(w));
        ce <= 1'b1;
        wr(LBP_IDX_SCRATCH, 8'h5a, 4'h1, LBP_RESP_OKAY);
        wr(LBP_IDX_REVISION, 8'h80, 4'h1, LBP_RESP_OKAY);
        general_resetn <= 1'b0;
        repeat (4) @(posedge aclk);
        general_resetn <= 1'b1;
        @(posedge aclk);
        rd(LBP_IDX_PWM_DUTY, 8'h00, LBP_RESP_OKAY);
        rd(LBP_IDX_BLINK_PULSE, 8'h00, LBP_RESP_OKAY);
        rd(LBP_IDX_SCRATCH, 8'h5a, LBP_RESP_OKAY);
        rd(LBP_IDX_REVISION, {4'h8, REV}, LBP_RESP_OKAY);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(LBP_IDX_SCRATCH, 8'h00, LBP_RESP_OKAY);
        rd(LBP_IDX_REVISION, {4'h0, REV}, LBP_RESP_OKAY);
        close_out();
    end
endmodule
